// file: src/stp_pkg.sv
// Shared constants, types and descriptor checks for the stream packet header codec
package stp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Packet geometry and datagram type
    localparam int          HDR_BYTES   = 13;
    localparam int          DATA_MAX    = 572;
    localparam int          LEN_W       = 10;
    localparam logic [7:0]  PROTO_TYPE  = 8'h07;

    // Descriptor field positions
    localparam int          DESC_CTL    = 7;
    localparam int          DESC_ACKREQ = 6;
    localparam int          DESC_EOM    = 5;
    localparam int          DESC_ATTN   = 4;

    // Control codes
    localparam logic [3:0]  CODE_PROBE_ACK = 4'h0;
    localparam logic [3:0]  CODE_OPEN_REQ  = 4'h1;
    localparam logic [3:0]  CODE_OPEN_ACK  = 4'h2;
    localparam logic [3:0]  CODE_OPEN_BOTH = 4'h3;
    localparam logic [3:0]  CODE_OPEN_DENY = 4'h4;
    localparam logic [3:0]  CODE_CLOSE     = 4'h5;
    localparam logic [3:0]  CODE_FWD_RST   = 4'h6;
    localparam logic [3:0]  CODE_FWD_ACK   = 4'h7;
    localparam logic [3:0]  CODE_RTX_ADV   = 4'h8;

    // Error codes reported on send refusal and on receive
    localparam logic [3:0]  ERR_NONE      = 4'h0;
    localparam logic [3:0]  ERR_TYPE      = 4'h1;
    localparam logic [3:0]  ERR_SHORT     = 4'h2;
    localparam logic [3:0]  ERR_LONG      = 4'h3;
    localparam logic [3:0]  ERR_CTL_DATA  = 4'h4;
    localparam logic [3:0]  ERR_ATTN_CODE = 4'h5;
    localparam logic [3:0]  ERR_EOM       = 4'h6;
    localparam logic [3:0]  ERR_CODE      = 4'h7;
    localparam logic [3:0]  ERR_ATTN_ACK  = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // Header in wire order, most significant byte first
    typedef struct packed {
        logic [15:0] connection_identifier;
        logic [31:0] pkt_first_byte_number;
        logic [31:0] pkt_next_expected_number;
        logic [15:0] pkt_receive_window;
        logic [7:0]  descriptor;
    } stp_hdr_s;

    typedef struct packed {
        logic probe;
        logic ack_request;
        logic close;
        logic fwd_reset;
        logic fwd_reset_ack;
        logic rtx_advice;
        logic open_dialog;
    } stp_evt_s;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_HDR,
        PH_PAY
    } stp_phase_e;

    ////////////////////////////////////////////////////////////////////////////////
    // Descriptor legality, used for both outgoing and incoming packets
    function automatic logic [3:0] stp_desc_check(input logic [7:0] d, input logic has_data);
        logic [3:0] err;
        err = ERR_NONE;
        if (d[DESC_EOM] && (d[DESC_CTL] || d[DESC_ATTN]))
            err = ERR_EOM;
        else if (d[DESC_ATTN] && d[3:0] != CODE_PROBE_ACK)
            err = ERR_ATTN_CODE;
        else if (d[DESC_ATTN] && d[DESC_CTL] && (d[DESC_ACKREQ] || has_data))
            err = ERR_ATTN_ACK;
        else if (d[DESC_ATTN] && !d[DESC_CTL] && !d[DESC_ACKREQ])
            err = ERR_ATTN_ACK;
        else if (d[DESC_CTL] && !d[DESC_ATTN] && has_data)
            err = ERR_CTL_DATA;
        else if (d[DESC_CTL] && d[3:0] > CODE_RTX_ADV)
            err = ERR_CODE;
        else if (!d[DESC_CTL] && d[3:0] != 4'h0)
            err = ERR_CODE;
        return err;
    endfunction

endpackage

// file: src/stp_hdr_tx.sv
// Header serializer and payload pacer for outgoing packets
`timescale 1ns/10ps
module stp_hdr_tx
    import stp_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             start,
    input  wire stp_hdr_s         hdr,
    input  wire logic [LEN_W-1:0] len,
    input  wire logic             pay_valid,
    input  wire logic [7:0]       pay_data,
    output logic                  pay_ready,
    input  wire logic             tx_ready,
    output logic                  tx_valid,
    output logic [7:0]            tx_data,
    output logic                  tx_last,
    output logic                  busy
);

    typedef struct packed {
        stp_phase_e        phase;
        logic [103:0]      shift;
        logic [3:0]        idx;
        logic [LEN_W-1:0]  remain;
        logic              tx_valid;
        logic [7:0]        tx_data;
        logic              tx_last;
        logic              pay_ready;
    } stp_txs_s;

    stp_txs_s st_r;
    stp_txs_s st_nxt;
    logic     slot_free;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt    = st_r;
        slot_free = !st_r.tx_valid || tx_ready;
        if (st_r.tx_valid && tx_ready)
        begin
            st_nxt.tx_valid = 1'b0;
            st_nxt.tx_last  = 1'b0;
        end
        case (st_r.phase)
            PH_IDLE:
            begin
                st_nxt.pay_ready = 1'b0;
                if (start)
                begin
                    st_nxt.shift  = hdr;
                    st_nxt.idx    = 4'h0;
                    st_nxt.remain = len;
                    st_nxt.phase  = PH_HDR;
                end
            end
            PH_HDR:
            begin
                if (slot_free)
                begin
                    // Most significant byte leaves first
                    st_nxt.tx_valid = 1'b1;
                    st_nxt.tx_data  = st_r.shift[103:96];
                    st_nxt.shift    = {st_r.shift[95:0], 8'h00};
                    st_nxt.idx      = st_r.idx + 4'h1;
                    st_nxt.tx_last  = (st_r.idx == 4'(HDR_BYTES - 1)) && (st_r.remain == '0);
                    if (st_r.idx == 4'(HDR_BYTES - 1))
                        st_nxt.phase = (st_r.remain == '0) ? PH_IDLE : PH_PAY;
                end
            end
            PH_PAY:
            begin
                // Half rate keeps ready a plain flop; fine for a 572 byte ceiling
                if (st_r.pay_ready && pay_valid)
                begin
                    st_nxt.tx_valid  = 1'b1;
                    st_nxt.tx_data   = pay_data;
                    st_nxt.tx_last   = (st_r.remain == LEN_W'(1));
                    st_nxt.remain    = st_r.remain - LEN_W'(1);
                    st_nxt.pay_ready = 1'b0;
                    if (st_r.remain == LEN_W'(1))
                        st_nxt.phase = PH_IDLE;
                end
                else if (!st_r.pay_ready)
                    st_nxt.pay_ready = slot_free;
            end
            default:
                st_nxt.phase = PH_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st_r <= '{phase: PH_IDLE, default: '0};
        else
            st_r <= st_nxt;
    end

    assign pay_ready = st_r.pay_ready;
    assign tx_valid  = st_r.tx_valid;
    assign tx_data   = st_r.tx_data;
    assign tx_last   = st_r.tx_last;
    assign busy      = (st_r.phase != PH_IDLE) || st_r.tx_valid;

endmodule

// file: src/stp_peer.sv
// Remote connection end: builds outgoing headers and parses incoming ones
// How it works
// - Header is 13 bytes, data at most 572
// - Only datagram type 7 is handled
// - Fields: id, first, next, window, descriptor
// - Control packets carry no data bytes
// - Attention message: control clear, ack request set
// - Attention control packet: ack request clear
// - Attention packets carry code zero only
// - End-of-message only on plain data packets
// - Control code sits in low four bits
// - Codes zero to eight mean documented types
`timescale 1ns/10ps
module stp_peer
    import stp_pkg::*;
#(
    parameter int MAX_DATA_P = DATA_MAX
)
(
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    input  wire logic             snd_valid,
    input  wire stp_hdr_s         snd_hdr,
    input  wire logic [LEN_W-1:0] snd_len,
    output logic                  snd_ready,
    output logic                  snd_reject,
    output logic [3:0]            snd_err,
    input  wire logic             pay_valid,
    input  wire logic [7:0]       pay_data,
    output logic                  pay_ready,
    output logic                  tx_valid,
    output logic [7:0]            tx_data,
    output logic                  tx_last,
    output logic [7:0]            tx_type,
    input  wire logic             tx_ready,
    input  wire logic             rx_valid,
    input  wire logic [7:0]       rx_data,
    input  wire logic             rx_last,
    input  wire logic [7:0]       rx_type,
    output logic                  rx_ready,
    output logic                  rcv_pay_valid,
    output logic [7:0]            rcv_pay_data,
    output logic                  rcv_done,
    output stp_hdr_s              rcv_hdr,
    output logic [LEN_W-1:0]      rcv_len,
    output logic [3:0]            rcv_err,
    output stp_evt_s              rcv_evt
);

    // Elaboration-time refusal of lengths the counters cannot hold
    if (MAX_DATA_P < 1 || MAX_DATA_P + HDR_BYTES > (1 << LEN_W) - 1)
    begin
        $error("MAX_DATA_P out of range for the length counters");
    end

    typedef struct packed {
        logic              snd_ready;
        logic              start;
        stp_hdr_s          hdr;
        logic [LEN_W-1:0]  len;
        logic              snd_reject;
        logic [3:0]        snd_err;
        logic [7:0]        tx_type;
        logic              rx_ready;
        logic [LEN_W-1:0]  rx_cnt;
        logic [103:0]      rx_shift;
        logic              rx_type_ok;
        logic              rcv_pay_valid;
        logic [7:0]        rcv_pay_data;
        logic              rcv_done;
        stp_hdr_s          rcv_hdr;
        logic [LEN_W-1:0]  rcv_len;
        logic [3:0]        rcv_err;
        stp_evt_s          rcv_evt;
    } stp_peer_s;

    stp_peer_s st_r;
    stp_peer_s st_nxt;
    logic      ser_busy;

    ////////////////////////////////////////////////////////////////////////////////
    // Outgoing header and payload
    stp_hdr_tx u_hdr_tx (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .start     (st_r.start),
        .hdr       (st_r.hdr),
        .len       (st_r.len),
        .pay_valid (pay_valid),
        .pay_data  (pay_data),
        .pay_ready (pay_ready),
        .tx_ready  (tx_ready),
        .tx_valid  (tx_valid),
        .tx_data   (tx_data),
        .tx_last   (tx_last),
        .busy      (ser_busy)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic [3:0]       err;
        logic [LEN_W-1:0] total;
        logic [LEN_W-1:0] pay_len;
        stp_hdr_s         hnow;
        logic [7:0]       d;
        err     = ERR_NONE;
        total   = '0;
        pay_len = '0;
        hnow    = '0;
        d       = 8'h00;
        st_nxt  = st_r;

        st_nxt.start      = 1'b0;
        st_nxt.snd_reject = 1'b0;
        st_nxt.tx_type    = PROTO_TYPE;
        st_nxt.rx_ready   = 1'b1;
        st_nxt.rcv_pay_valid = 1'b0;
        st_nxt.rcv_done   = 1'b0;
        st_nxt.rcv_evt    = '0;

        // Send side: refuse any illegal header before a byte goes out
        if (st_r.snd_ready && snd_valid)
        begin
            st_nxt.snd_ready = 1'b0;
            if (snd_len > LEN_W'(MAX_DATA_P))
                err = ERR_LONG;
            else
                err = stp_desc_check(snd_hdr.descriptor, snd_len != '0);
            st_nxt.snd_err = err;
            if (err == ERR_NONE)
            begin
                st_nxt.start = 1'b1;
                st_nxt.hdr   = snd_hdr;
                st_nxt.len   = snd_len;
            end
            else
                st_nxt.snd_reject = 1'b1;
        end
        else if (!st_r.snd_ready && !st_r.start && !ser_busy)
            st_nxt.snd_ready = 1'b1;

        // Receive side
        if (rx_valid && st_r.rx_ready)
        begin
            if (st_r.rx_cnt == '0)
                st_nxt.rx_type_ok = (rx_type == PROTO_TYPE);
            if (st_r.rx_cnt < LEN_W'(HDR_BYTES))
                st_nxt.rx_shift = {st_r.rx_shift[95:0], rx_data};
            else if (st_r.rx_type_ok)
            begin
                st_nxt.rcv_pay_valid = 1'b1;
                st_nxt.rcv_pay_data  = rx_data;
            end
            if (st_r.rx_cnt != '1)
                st_nxt.rx_cnt = st_r.rx_cnt + LEN_W'(1);

            if (rx_last)
            begin
                // Counter saturates, so a runaway packet still reads as oversize
                total = (st_r.rx_cnt == '1) ? st_r.rx_cnt : st_r.rx_cnt + LEN_W'(1);
                hnow  = (st_r.rx_cnt < LEN_W'(HDR_BYTES)) ?
                        {st_r.rx_shift[95:0], rx_data} : st_r.rx_shift;
                d     = hnow.descriptor;
                pay_len = (total > LEN_W'(HDR_BYTES)) ? total - LEN_W'(HDR_BYTES) : '0;
                if (!((st_r.rx_cnt == '0) ? (rx_type == PROTO_TYPE) : st_r.rx_type_ok))
                    err = ERR_TYPE;
                else if (total < LEN_W'(HDR_BYTES))
                    err = ERR_SHORT;
                else if (pay_len > LEN_W'(MAX_DATA_P))
                    err = ERR_LONG;
                else
                    err = stp_desc_check(d, pay_len != '0);
                st_nxt.rcv_done = 1'b1;
                st_nxt.rcv_hdr  = hnow;
                st_nxt.rcv_len  = pay_len;
                st_nxt.rcv_err  = err;
                st_nxt.rx_cnt   = '0;
                if (err == ERR_NONE)
                begin
                    st_nxt.rcv_evt.ack_request = d[DESC_ACKREQ];
                    if (d[DESC_CTL] && !d[DESC_ATTN])
                    begin
                        case (d[3:0])
                            CODE_PROBE_ACK: st_nxt.rcv_evt.probe = d[DESC_ACKREQ];
                            CODE_OPEN_REQ,
                            CODE_OPEN_ACK,
                            CODE_OPEN_BOTH,
                            CODE_OPEN_DENY: st_nxt.rcv_evt.open_dialog = 1'b1;
                            CODE_CLOSE:     st_nxt.rcv_evt.close = 1'b1;
                            CODE_FWD_RST:   st_nxt.rcv_evt.fwd_reset = 1'b1;
                            CODE_FWD_ACK:   st_nxt.rcv_evt.fwd_reset_ack = 1'b1;
                            CODE_RTX_ADV:   st_nxt.rcv_evt.rtx_advice = 1'b1;
                            default:        st_nxt.rcv_evt = '0;
                        endcase
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign snd_ready     = st_r.snd_ready;
    assign snd_reject    = st_r.snd_reject;
    assign snd_err       = st_r.snd_err;
    assign tx_type       = st_r.tx_type;
    assign rx_ready      = st_r.rx_ready;
    assign rcv_pay_valid = st_r.rcv_pay_valid;
    assign rcv_pay_data  = st_r.rcv_pay_data;
    assign rcv_done      = st_r.rcv_done;
    assign rcv_hdr       = st_r.rcv_hdr;
    assign rcv_len       = st_r.rcv_len;
    assign rcv_err       = st_r.rcv_err;
    assign rcv_evt       = st_r.rcv_evt;

endmodule

// file: verif/stp_peer_properties.sv
// Port-level checker for the packet header codec
`timescale 1ns/10ps
module stp_peer_chk
    import stp_pkg::*;
#(
    parameter int MAX_DATA_P = DATA_MAX
)
(
    input wire logic             core_clk,
    input wire logic             reset_n,
    input wire logic             snd_valid,
    input wire logic             snd_ready,
    input wire logic [LEN_W-1:0] snd_len,
    input wire logic             snd_reject,
    input wire logic [3:0]       snd_err,
    input wire logic             tx_valid,
    input wire logic [7:0]       tx_type,
    input wire logic             rx_valid,
    input wire logic             rx_last,
    input wire logic             rx_ready,
    input wire logic             rcv_done,
    input wire stp_hdr_s         rcv_hdr,
    input wire logic [3:0]       rcv_err,
    input wire stp_evt_s         rcv_evt
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////
    type_out_a: assert property (tx_valid |-> tx_type == PROTO_TYPE)
        else $error("outgoing datagram type wrong");
    long_refuse_a: assert property (snd_valid && snd_ready && snd_len > MAX_DATA_P
        |=> snd_reject && snd_err == ERR_LONG) else $error("oversize send not refused");
    send_answer_a: assert property (snd_valid && snd_ready
        |=> snd_reject or ##[1:3] tx_valid) else $error("send request left unanswered");
    refuse_code_a: assert property (snd_reject |-> snd_err != ERR_NONE)
        else $error("refusal without error code");
    evt_clean_a: assert property (rcv_evt != '0 |-> rcv_done && rcv_err == ERR_NONE)
        else $error("event from invalid packet");
    close_evt_a: assert property (rcv_evt.close |-> rcv_hdr.descriptor[3:0] == CODE_CLOSE)
        else $error("close event on wrong code");
    fwd_evt_a: assert property (rcv_evt.fwd_reset |-> rcv_hdr.descriptor[3:0] == CODE_FWD_RST)
        else $error("forward reset event on wrong code");
    probe_evt_a: assert property (rcv_evt.probe
        |-> rcv_hdr.descriptor[DESC_ACKREQ] && rcv_hdr.descriptor[3:0] == CODE_PROBE_ACK)
        else $error("probe event without ack request");
    done_after_a: assert property (rx_valid && rx_ready && rx_last |=> rcv_done)
        else $error("packet end not reported");
    cover property (rcv_evt.probe);
    cover property (snd_reject);
    cover property (rcv_evt.fwd_reset_ack);
endmodule
bind stp_peer stp_peer_chk #(.MAX_DATA_P(MAX_DATA_P)) u_stp_peer_chk (
    .core_clk(core_clk), .reset_n(reset_n), .snd_valid(snd_valid), .snd_ready(snd_ready),
    .snd_len(snd_len), .snd_reject(snd_reject), .snd_err(snd_err), .tx_valid(tx_valid),
    .tx_type(tx_type), .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready),
    .rcv_done(rcv_done), .rcv_hdr(rcv_hdr), .rcv_err(rcv_err), .rcv_evt(rcv_evt)
);

// file: verif/stp_dev_model.sv
// Behavioural remote connection end answering the codec
`timescale 1ns/10ps
module stp_dev_model
    import stp_pkg::*;
#(
    parameter logic [15:0] BUF_SIZE = 16'h0400,
    parameter logic [15:0] CONN_ID  = 16'h00a5
)
(
    input  wire logic       core_clk,
    input  wire logic       reset_n,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    input  wire logic [7:0] tx_type,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_last,
    output logic [7:0]      rx_type,
    input  wire logic       rx_ready
);
    logic [7:0]  cap[0:599];
    int          n_cap, n_got, n_pkt;
    logic [7:0]  last_type;
    logic        slow, rep_due;
    logic [3:0]  rep_code;
    logic [31:0] next_send_number, oldest_unacked_number, send_window_limit;
    logic [31:0] next_receive_number, lim;
    logic [15:0] receive_window_bytes;
    stp_hdr_s    h;
    initial
    begin
        {tx_ready, rx_valid, rx_data, rx_last, rx_type} = {1'b1, 18'h0};
        {slow, rep_due, n_cap, n_pkt} = '0;
        next_send_number = 32'h0;
        oldest_unacked_number = next_send_number;
        send_window_limit = 32'h0;
        next_receive_number = 32'h0;
        receive_window_bytes = BUF_SIZE;
    end
    ////////////////////////////////////////////////////////////
    task automatic send_pkt(input logic [7:0] typ, input stp_hdr_s hh, input int tot);
        for (int i = 0; i < tot; i++)
        begin
            rx_valid <= 1'b1;
            rx_type  <= typ;
            rx_data  <= (i < HDR_BYTES) ? hh[103-8*i -: 8] : i[7:0];
            rx_last  <= (i == tot - 1);
            do @(posedge core_clk); while (!rx_ready);
        end
        rx_valid <= 1'b0;
        rx_last  <= 1'b0;
        rx_data  <= ~rx_data;
    endtask
    // Bookkeeping; replies leave below
    function automatic void take_pkt();
        for (int i = 0; i < HDR_BYTES; i++)
            h = {h[95:0], cap[i]};
        n_got = n_cap;
        n_cap = 0;
        n_pkt++;
        if (last_type != PROTO_TYPE)
            return;
        lim = h.pkt_next_expected_number + h.pkt_receive_window - 32'h1;
        if (lim > send_window_limit)
            send_window_limit = lim;
        if (h.pkt_next_expected_number >= oldest_unacked_number &&
            h.pkt_next_expected_number <= next_send_number)
            oldest_unacked_number = h.pkt_next_expected_number;
        if (!h.descriptor[DESC_CTL] && h.pkt_first_byte_number == next_receive_number)
            next_receive_number += n_got - HDR_BYTES;
        rep_code = CODE_PROBE_ACK;
        rep_due = h.descriptor[DESC_ACKREQ];
        if (h.descriptor[DESC_CTL] && h.descriptor[3:0] == CODE_FWD_RST)
        begin
            if (h.pkt_first_byte_number >= next_receive_number &&
                h.pkt_first_byte_number <= next_receive_number + receive_window_bytes)
                next_receive_number = h.pkt_first_byte_number;
            rep_code = CODE_FWD_ACK;
            rep_due = 1'b1;
        end
    endfunction
    always @(posedge core_clk)
    begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (reset_n && tx_valid && tx_ready)
        begin
            cap[n_cap] = tx_data;
            n_cap++;
            last_type = tx_type;
            if (tx_last)
                take_pkt();
        end
    end
    initial
    begin
        forever
        begin
            @(posedge core_clk);
            if (rep_due)
            begin
                rep_due = 1'b0;
                send_pkt(PROTO_TYPE, {CONN_ID, next_send_number, next_receive_number,
                    receive_window_bytes, 4'h8, rep_code}, HDR_BYTES);
            end
        end
    end
endmodule

// file: verif/tb_stream_packet_header_codec.sv
// Self-checking bench: codec against the device model
`timescale 1ns/10ps
`define CHK(nm, got, exp) \
begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
        failures++; \
        $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
end
module tb_stream_packet_header_codec
    import stp_pkg::*;
;
    logic             core_clk  = 1'b0;
    logic             reset_n   = 1'b0;
    logic             snd_valid = 1'b0;
    stp_hdr_s         snd_hdr   = '0;
    logic [LEN_W-1:0] snd_len   = '0;
    logic             pay_valid = 1'b1;
    logic [7:0]       pay_data  = 8'h00;
    logic             snd_ready, snd_reject, pay_ready, tx_valid, tx_last, tx_ready;
    logic             rx_valid, rx_last, rx_ready, rcv_pay_valid, rcv_done;
    logic [3:0]       snd_err, rcv_err;
    logic [7:0]       tx_data, tx_type, rx_data, rx_type, rcv_pay_data;
    logic [LEN_W-1:0] rcv_len;
    stp_hdr_s         rcv_hdr;
    stp_evt_s         rcv_evt;
    int               failures   = 0;
    int               n_compared = 0;
    int               i;
    logic [7:0]       ex[16] = '{8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                 8'h00, 8'h00, 8'h01, 8'h00, 8'h40, 8'h00, 8'h01, 8'h02};
    logic [23:0]      txt[8] = '{{8'h00, ERR_LONG, 12'd573}, {8'h80, ERR_CTL_DATA, 12'd1},
        {8'h51, ERR_ATTN_CODE, 12'd1}, {8'ha0, ERR_EOM, 12'd0}, {8'hd0, ERR_ATTN_ACK, 12'd0},
        {8'h10, ERR_ATTN_ACK, 12'd1}, {8'h89, ERR_CODE, 12'd0}, {8'h03, ERR_CODE, 12'd1}};
    logic [31:0]      rxt[8] = '{{8'h06, 8'h00, ERR_TYPE, 12'd16},
        {PROTO_TYPE, 8'h00, ERR_SHORT, 12'd5}, {PROTO_TYPE, 8'h00, ERR_LONG, 12'd586},
        {PROTO_TYPE, 8'h00, ERR_NONE, 12'd585}, {PROTO_TYPE, 8'ha0, ERR_EOM, 12'd13},
        {PROTO_TYPE, 8'h53, ERR_ATTN_CODE, 12'd13}, {PROTO_TYPE, 8'h80, ERR_CTL_DATA, 12'd14},
        {PROTO_TYPE, 8'h00, ERR_NONE, 12'd16}};
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk)
        if (pay_valid && pay_ready)
            pay_data <= pay_data + 8'h01;
    stp_peer u_stp_peer (.core_clk(core_clk), .reset_n(reset_n), .snd_valid(snd_valid),
        .snd_hdr(snd_hdr), .snd_len(snd_len), .snd_ready(snd_ready), .snd_reject(snd_reject),
        .snd_err(snd_err), .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_type(tx_type),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_type(rx_type), .rx_ready(rx_ready), .rcv_pay_valid(rcv_pay_valid),
        .rcv_pay_data(rcv_pay_data), .rcv_done(rcv_done), .rcv_hdr(rcv_hdr),
        .rcv_len(rcv_len), .rcv_err(rcv_err), .rcv_evt(rcv_evt));
    stp_dev_model u_stp_dev_model (.core_clk(core_clk), .reset_n(reset_n),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_type(tx_type),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_type(rx_type), .rx_ready(rx_ready));
    ////////////////////////////////////////////////////////////
    function automatic stp_hdr_s hd(input logic [31:0] f, input logic [7:0] d);
        hd = {16'h1234, f, 32'h0, 16'h0100, d};
    endfunction
    function automatic stp_evt_s ev(input logic [3:0] c, input logic a);
        ev = '0;
        ev.ack_request = a;
        ev.probe = a && c == CODE_PROBE_ACK;
        ev.open_dialog = c >= CODE_OPEN_REQ && c <= CODE_OPEN_DENY;
        ev.close = c == CODE_CLOSE;
        ev.fwd_reset = c == CODE_FWD_RST;
        ev.fwd_reset_ack = c == CODE_FWD_ACK;
        ev.rtx_advice = c == CODE_RTX_ADV;
    endfunction
    task automatic final_report();
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Held one edge: snd_ready is high when raised
    task automatic snd(input stp_hdr_s h, input int n, input logic [3:0] e);
        int k;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (snd_ready !== 1'b1 && k < 500);
        snd_valid <= 1'b1;
        snd_hdr   <= h;
        snd_len   <= n[LEN_W-1:0];
        @(posedge core_clk);
        snd_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
        `CHK("snd_err", snd_err, e)
    endtask
    task automatic wait_pkt(input int n);
        for (int k = 0; k < 3000 && u_stp_dev_model.n_pkt < n; k++)
            @(posedge core_clk);
    endtask
    task automatic rcv(input logic [3:0] e, input stp_evt_s v);
        for (int k = 0; k < 300 && rcv_done !== 1'b1; k++)
            @(posedge core_clk);
        `CHK("rcv_done", rcv_done, 1'b1)
        `CHK("rcv_err", rcv_err, e)
        `CHK("rcv_evt", rcv_evt, v)
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        u_stp_dev_model.slow = 1'b1;
        snd(hd(32'h0, 8'h40), 3, ERR_NONE);
        wait_pkt(1);
        u_stp_dev_model.slow = 1'b0;
        `CHK("byte count", u_stp_dev_model.n_got, HDR_BYTES + 3)
        `CHK("tx type", u_stp_dev_model.last_type, PROTO_TYPE)
        for (i = 0; i < 16; i++)
            `CHK("tx byte", u_stp_dev_model.cap[i], ex[i])
        rcv(ERR_NONE, '0);
        `CHK("ack next", rcv_hdr.pkt_next_expected_number, 32'h3)
        `CHK("ack window", rcv_hdr.pkt_receive_window, 16'h0400)
        `CHK("ack first", rcv_hdr.pkt_first_byte_number, 32'h0)
        for (i = 0; i < 8; i++)
            snd(hd(32'h3, txt[i][23:16]), int'(txt[i][11:0]), txt[i][15:12]);
        snd(hd(32'h3, 8'hc0), 0, ERR_NONE);
        wait_pkt(2);
        rcv(ERR_NONE, '0);
        snd(hd(32'h5, 8'h86), 0, ERR_NONE);
        wait_pkt(3);
        rcv(ERR_NONE, ev(CODE_FWD_ACK, 1'b0));
        `CHK("fwd next", rcv_hdr.pkt_next_expected_number, 32'h5)
        snd(hd(32'h8000_0000, 8'h86), 0, ERR_NONE);
        wait_pkt(4);
        rcv(ERR_NONE, ev(CODE_FWD_ACK, 1'b0));
        `CHK("fwd kept", rcv_hdr.pkt_next_expected_number, 32'h5)
        snd(hd(32'h5, 8'h85), 0, ERR_NONE);
        wait_pkt(5);
        for (i = 0; i <= 16; i++)
        begin
            u_stp_dev_model.send_pkt(PROTO_TYPE, hd(0, {1'b1, i == 16, 2'b00, i[3:0]}), 13);
            rcv(i[3:0] > CODE_RTX_ADV ? ERR_CODE : ERR_NONE, ev(i[3:0], i == 16));
        end
        for (i = 0; i < 8; i++)
        begin
            u_stp_dev_model.send_pkt(rxt[i][31:24], hd(0, rxt[i][23:16]), int'(rxt[i][11:0]));
            rcv(rxt[i][15:12], '0);
        end
        `CHK("rcv_len", rcv_len, 10'd3)
        `CHK("rcv_pay_data", rcv_pay_data, 8'h0f)
        final_report();
    end
    initial
    begin
        repeat (30000) @(posedge core_clk);
        failures++;
        final_report();
    end
endmodule
